// ===== hdl/civ_pkg.sv
// shared constants for the interrupt vectoring host controller
package civ_pkg;
    // restart opcode layout: 11 nnn 111
    localparam logic [1:0]  RST_OP_HI        = 2'h3;
    localparam logic [2:0]  RST_OP_LO        = 3'h7;
    localparam logic [7:0]  RST_OP_FIRST     = 8'hC7;
    localparam logic [7:0]  RST_OP_LAST      = 8'hFF;
    localparam int          RST_NUM_POS      = 3;
    localparam int          RST_ADDR_SHIFT   = 3;
    // fixed service locations of the direct host
    localparam logic [15:0] DIRECT_VEC_ZERO  = 16'h0003;
    localparam logic [15:0] DIRECT_VEC_ONE   = 16'h0013;
    // external data space reachable with the low port alone
    localparam int          LOW_SPACE_BYTES  = 256;
    // timing counts in clock cycles at 50 MHz
    localparam int          ACK_CYCLES       = 2;
    localparam int          ALE_CYCLES       = 1;
    localparam int          DATA_CYCLES      = 2;
    // reset values
    localparam logic [15:0] PC_RESET         = 16'h0000;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;

    // controller states
    typedef enum logic [1:0] {
        CIV_IDLE    = 2'b00,
        CIV_WAIT    = 2'b01,
        CIV_ACK     = 2'b10,
        CIV_SERVICE = 2'b11
    } civ_state_t;

    // bus cycle states
    typedef enum logic [1:0] {
        CIV_B_IDLE = 2'b00,
        CIV_B_ADDR = 2'b01,
        CIV_B_DATA = 2'b10
    } civ_bstate_t;
endpackage

// ===== hdl/civ_vec_buf.sv
// vector buffer gated by peripheral request and host acknowledge
`timescale 1ns/100ps
module civ_vec_buf #(
    parameter logic [7:0] VEC_OPCODE = 8'hE7
) (
    input  wire logic       clk_i,          // system clock
    input  wire logic       rst_i,          // synchronous reset
    input  wire logic       periph_irq_n_i, // peripheral request, low active
    input  wire logic       nxt_ack_n_i,    // next acknowledge level, low active
    output logic      [7:0] vbus_o,         // opcode toward data bus
    output logic            vbus_oe_o       // high while buffer drives bus
);
    logic [7:0] vbus_ff;
    logic       vbus_oe_ff;

    // enable only in the qualified acknowledge cycle, otherwise release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vbus_oe_ff <= 1'b0;
            vbus_ff    <= civ_pkg::BYTE_RESET;
        end else begin
            vbus_oe_ff <= ~periph_irq_n_i & ~nxt_ack_n_i; // RL15 RL16
            vbus_ff    <= (~periph_irq_n_i & ~nxt_ack_n_i) ? VEC_OPCODE
                                                          : civ_pkg::BYTE_RESET;
        end
    end

    assign vbus_o    = vbus_ff;
    assign vbus_oe_o = vbus_oe_ff;
endmodule

// ===== hdl/civ_bus_cycle.sv
// multiplexed address/data memory cycle of the direct host
`timescale 1ns/100ps
module civ_bus_cycle #(
    parameter bit WIDE_SPACE = 1'b1
) (
    input  wire logic        clk_i,     // system clock
    input  wire logic        rst_i,     // synchronous reset
    input  wire logic        req_i,     // start a memory cycle
    input  wire logic        we_i,      // write when high
    input  wire logic [15:0] addr_i,    // cycle address
    input  wire logic [7:0]  wdata_i,   // write data
    input  wire logic [7:0]  p0_i,      // low port level
    output logic             busy_o,    // cycle in progress
    output logic             done_o,    // one-cycle end pulse
    output logic      [7:0]  rdata_o,   // read data
    output logic             ale_o,     // address latch strobe
    output logic      [7:0]  p0_o,      // low port drive value
    output logic             p0_oe_o,   // low port drive enable
    output logic      [7:0]  p2_o       // upper address byte
);
    civ_pkg::civ_bstate_t state_ff;
    logic [1:0] cnt_ff;
    logic       we_ff;
    logic [7:0] wdata_ff;
    logic       ale_ff;
    logic       done_ff;
    logic [7:0] rdata_ff;
    logic [7:0] p0_ff;
    logic       p0_oe_ff;
    logic [7:0] p2_ff;

    // address phase then data phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= civ_pkg::CIV_B_IDLE;
            cnt_ff   <= 2'h0;
            we_ff    <= 1'b0;
            wdata_ff <= civ_pkg::BYTE_RESET;
            ale_ff   <= 1'b0;
            done_ff  <= 1'b0;
            rdata_ff <= civ_pkg::BYTE_RESET;
            p0_ff    <= civ_pkg::BYTE_RESET;
            p0_oe_ff <= 1'b0;
            p2_ff    <= civ_pkg::BYTE_RESET;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                civ_pkg::CIV_B_IDLE: begin
                    if (req_i) begin
                        state_ff <= civ_pkg::CIV_B_ADDR;
                        cnt_ff   <= 2'(civ_pkg::ALE_CYCLES - 1);
                        we_ff    <= we_i;
                        wdata_ff <= wdata_i;
                        ale_ff   <= 1'b1;                  // RL11
                        p0_ff    <= addr_i[7:0];           // RL11
                        p0_oe_ff <= 1'b1;
                        p2_ff    <= WIDE_SPACE ? addr_i[15:8]
                                               : civ_pkg::BYTE_RESET; // RL13
                    end
                end
                civ_pkg::CIV_B_ADDR: begin
                    if (cnt_ff == 2'h0) begin
                        state_ff <= civ_pkg::CIV_B_DATA;
                        cnt_ff   <= 2'(civ_pkg::DATA_CYCLES - 1);
                        ale_ff   <= 1'b0;
                        p0_ff    <= we_ff ? wdata_ff : civ_pkg::BYTE_RESET; // RL12
                        p0_oe_ff <= we_ff;                 // RL12
                    end else begin
                        cnt_ff <= cnt_ff - 2'h1;
                    end
                end
                civ_pkg::CIV_B_DATA: begin
                    if (cnt_ff == 2'h0) begin
                        state_ff <= civ_pkg::CIV_B_IDLE;
                        done_ff  <= 1'b1;
                        rdata_ff <= we_ff ? rdata_ff : p0_i;
                        p0_oe_ff <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff - 2'h1;
                    end
                end
                default: begin
                    state_ff <= civ_pkg::CIV_B_IDLE;
                    ale_ff   <= 1'b0;
                    p0_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign busy_o  = (state_ff != civ_pkg::CIV_B_IDLE);
    assign done_o  = done_ff;
    assign rdata_o = rdata_ff;
    assign ale_o   = ale_ff;
    assign p0_o    = p0_ff;
    assign p0_oe_o = p0_oe_ff;
    assign p2_o    = p2_ff;
endmodule

// ===== hdl/civ_host.sv
// host side interrupt controller: direct and vectored styles
//
// Behaviour
// [RL1] peripheral pulls request low for service
// [RL2] peripheral releases request after causes cleared
// [RL3] direct host gives no acknowledge, branches
// [RL4] input zero to 0003H, one to 0013H
// [RL5] vectored host request input is active high
// [RL6] enable output high while interrupts enabled
// [RL7] finish instruction, then drive acknowledge low
// [RL8] expect one vector byte during acknowledge
// [RL9] restart opcodes C7..FF map to 0000..0038
// [RL10] load program counter with restart address
// [RL11] latch strobe captures low address first
// [RL12] low port carries data second half
// [RL13] upper address byte on second port
// [RL14] peripheral request inverted before host input
// [RL15] buffer enabled only when request and acknowledge low
// [RL16] buffer leaves data bus undriven otherwise
`timescale 1ns/100ps
module civ_host #(
    parameter logic [7:0] VEC_OPCODE = 8'hE7,  // opcode wired into the buffer
    parameter bit         WIDE_SPACE = 1'b1    // external space above 256 bytes
) (
    input  wire logic        clk_i,            // system clock
    input  wire logic        rst_i,            // synchronous reset
    input  wire logic        mode_vectored_i,  // 1 vectored style, 0 direct
    input  wire logic        ei_i,             // enable interrupts pulse
    input  wire logic        di_i,             // disable interrupts pulse
    input  wire logic        insn_done_i,      // current instruction completes
    input  wire logic        periph_irq_n_i,   // peripheral request, low active
    input  wire logic        ext_irq_zero_n_i, // direct input zero, low active
    input  wire logic        ext_irq_one_n_i,  // direct input one, low active
    input  wire logic [7:0]  vbus_i,           // resolved vector data bus
    input  wire logic        mem_req_i,        // start external memory cycle
    input  wire logic        mem_we_i,         // memory write when high
    input  wire logic [15:0] mem_addr_i,       // memory address
    input  wire logic [7:0]  mem_wdata_i,      // memory write data
    input  wire logic [7:0]  p0_i,             // low port level
    output logic             host_irq_o,       // inverted request at host input
    output logic             host_irq_enabled_o, // interrupts accepted
    output logic             host_int_ack_n_o, // acknowledge strobe, low active
    output logic      [7:0]  vbus_o,           // vector buffer drive value
    output logic             vbus_oe_o,        // vector buffer drive enable
    output logic             pc_load_o,        // program counter load pulse
    output logic      [15:0] pc_target_o,      // service routine address
    output logic             in_service_o,     // service routine running
    output logic             vec_err_o,        // pulse on non-restart vector
    output logic             mem_done_o,       // memory cycle end pulse
    output logic      [7:0]  mem_rdata_o,      // memory read data
    output logic             ale_o,            // address latch strobe
    output logic      [7:0]  p0_o,             // low port drive value
    output logic             p0_oe_o,          // low port drive enable
    output logic      [7:0]  p2_o              // upper address byte
);
    civ_pkg::civ_state_t state_ff;
    civ_pkg::civ_state_t nxt_state;
    logic        host_irq_ff;
    logic        enabled_ff;
    logic        ack_n_ff;
    logic        nxt_ack_n;
    logic [1:0]  ack_cnt_ff;
    logic        pc_load_ff;
    logic [15:0] pc_target_ff;
    logic        vec_err_ff;
    logic        direct_one_ff;
    logic        direct_req;
    logic        vec_req;
    logic        req_live;
    logic        mem_busy;

    // restart opcode check
    function automatic logic is_restart(input logic [7:0] op);
        is_restart = (op[7:6] == civ_pkg::RST_OP_HI) && (op[2:0] == civ_pkg::RST_OP_LO);
    endfunction

    // restart number times eight gives the target
    function automatic logic [15:0] restart_addr(input logic [7:0] op);
        logic [15:0] num;
        num          = {13'h0000, op[civ_pkg::RST_NUM_POS +: 3]};
        restart_addr = num << civ_pkg::RST_ADDR_SHIFT;
    endfunction

    // request as seen by each host style
    assign direct_req = ~ext_irq_zero_n_i | ~ext_irq_one_n_i;
    assign vec_req    = host_irq_ff;                              // RL5
    assign req_live   = mode_vectored_i ? vec_req : direct_req;

    // glue inverter between peripheral and vectored host input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_irq_ff <= 1'b0;
        end else begin
            host_irq_ff <= ~periph_irq_n_i;                       // RL1 RL14
        end
    end

    // interrupt enable, dropped when a request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enabled_ff <= 1'b0;
        end else if (state_ff == civ_pkg::CIV_WAIT && insn_done_i) begin
            enabled_ff <= 1'b0;
        end else if (di_i) begin
            enabled_ff <= 1'b0;
        end else if (ei_i) begin
            enabled_ff <= 1'b1;                                   // RL6
        end
    end

    // next state of the interrupt sequence
    always_comb begin
        nxt_state = state_ff;
        nxt_ack_n = ack_n_ff;
        case (state_ff)
            civ_pkg::CIV_IDLE: begin
                if (enabled_ff && req_live) begin                 // RL6
                    nxt_state = civ_pkg::CIV_WAIT;
                end
            end
            civ_pkg::CIV_WAIT: begin
                if (!req_live) begin
                    nxt_state = civ_pkg::CIV_IDLE;
                end else if (insn_done_i) begin                   // RL7
                    if (mode_vectored_i) begin
                        nxt_state = civ_pkg::CIV_ACK;
                        nxt_ack_n = 1'b0;                         // RL7
                    end else begin
                        nxt_state = civ_pkg::CIV_SERVICE;         // RL3
                    end
                end
            end
            civ_pkg::CIV_ACK: begin
                if (ack_cnt_ff == 2'h0) begin
                    nxt_ack_n = 1'b1;
                    nxt_state = is_restart(vbus_i) ? civ_pkg::CIV_SERVICE
                                                   : civ_pkg::CIV_IDLE;
                end
            end
            civ_pkg::CIV_SERVICE: begin
                if (!req_live) begin                              // RL2
                    nxt_state = civ_pkg::CIV_IDLE;
                end
            end
            default: begin
                nxt_state = civ_pkg::CIV_IDLE;
                nxt_ack_n = 1'b1;
            end
        endcase
    end

    // state, acknowledge strobe and its length counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff   <= civ_pkg::CIV_IDLE;
            ack_n_ff   <= 1'b1;
            ack_cnt_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            ack_n_ff <= nxt_ack_n;
            if (state_ff != civ_pkg::CIV_ACK) begin
                ack_cnt_ff <= 2'(civ_pkg::ACK_CYCLES - 1);
            end else if (ack_cnt_ff != 2'h0) begin
                ack_cnt_ff <= ack_cnt_ff - 2'h1;
            end
        end
    end

    // direct input priority: zero before one, caught while idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            direct_one_ff <= 1'b0;
        end else if (state_ff == civ_pkg::CIV_IDLE) begin
            direct_one_ff <= ext_irq_zero_n_i & ~ext_irq_one_n_i;
        end
    end

    // program counter load for both styles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_load_ff   <= 1'b0;
            pc_target_ff <= civ_pkg::PC_RESET;
            vec_err_ff   <= 1'b0;
        end else begin
            pc_load_ff <= 1'b0;
            vec_err_ff <= 1'b0;
            if (state_ff == civ_pkg::CIV_WAIT && nxt_state == civ_pkg::CIV_SERVICE) begin
                pc_load_ff   <= 1'b1;                             // RL3
                pc_target_ff <= direct_one_ff ? civ_pkg::DIRECT_VEC_ONE
                                              : civ_pkg::DIRECT_VEC_ZERO; // RL4
            end else if (state_ff == civ_pkg::CIV_ACK && ack_cnt_ff == 2'h0) begin
                if (is_restart(vbus_i)) begin                     // RL8 RL9
                    pc_load_ff   <= 1'b1;                         // RL10
                    pc_target_ff <= restart_addr(vbus_i);         // RL9 RL10
                end else begin
                    vec_err_ff <= 1'b1;
                end
            end
        end
    end

    // vector buffer fed with next acknowledge so it tracks the strobe
    civ_vec_buf #(
        .VEC_OPCODE (VEC_OPCODE)
    ) u_vec_buf (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .periph_irq_n_i (periph_irq_n_i),
        .nxt_ack_n_i    (nxt_ack_n),                              // RL15
        .vbus_o         (vbus_o),
        .vbus_oe_o      (vbus_oe_o)
    );

    // multiplexed external memory cycles of the direct host
    civ_bus_cycle #(
        .WIDE_SPACE (WIDE_SPACE)
    ) u_bus_cycle (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .req_i   (mem_req_i),
        .we_i    (mem_we_i),
        .addr_i  (mem_addr_i),
        .wdata_i (mem_wdata_i),
        .p0_i    (p0_i),
        .busy_o  (mem_busy),
        .done_o  (mem_done_o),
        .rdata_o (mem_rdata_o),
        .ale_o   (ale_o),
        .p0_o    (p0_o),
        .p0_oe_o (p0_oe_o),
        .p2_o    (p2_o)
    );

    // register driven outputs, with in_service_o decoded from the state register
    assign host_irq_o         = host_irq_ff;
    assign host_irq_enabled_o = enabled_ff;
    assign host_int_ack_n_o   = ack_n_ff;
    assign pc_load_o          = pc_load_ff;
    assign pc_target_o        = pc_target_ff;
    assign in_service_o       = (state_ff == civ_pkg::CIV_SERVICE);
    assign vec_err_o          = vec_err_ff;
endmodule

// ===== verif/civ_host_monitor.sv
// port checks for the host interrupt controller
`timescale 1ns/100ps
module civ_host_monitor #(
    parameter logic [7:0] VEC_OPCODE = 8'hE7
) (
    input wire logic        clk_i,              // clock
    input wire logic        rst_i,              // reset
    input wire logic        mode_vectored_i,    // host style
    input wire logic        ei_i,               // enable pulse
    input wire logic        di_i,               // disable pulse
    input wire logic        insn_done_i,        // insn end
    input wire logic        periph_irq_n_i,     // request
    input wire logic        ext_irq_zero_n_i,   // input zero
    input wire logic        ext_irq_one_n_i,    // input one
    input wire logic [7:0]  vbus_i,             // vector bus
    input wire logic [15:0] mem_addr_i,         // mem address
    input wire logic        host_irq_o,         // host request
    input wire logic        host_irq_enabled_o, // enabled
    input wire logic        host_int_ack_n_o,   // acknowledge
    input wire logic [7:0]  vbus_o,             // buffer byte
    input wire logic        vbus_oe_o,          // buffer drive
    input wire logic        pc_load_o,          // pc load
    input wire logic [15:0] pc_target_o,        // pc target
    input wire logic        vec_err_o,          // bad vector
    input wire logic        mem_done_o,         // mem end
    input wire logic        ale_o,              // latch strobe
    input wire logic [7:0]  p0_o,               // low port
    input wire logic        p0_oe_o,            // low port drive
    input wire logic [7:0]  p2_o                // upper port
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ack window, byte taken at its last edge
    sequence ack_open_s;
        $fell(host_int_ack_n_o) ##1 !host_int_ack_n_o;
    endsequence
    sequence good_byte_s;
        ack_open_s ##0 (vbus_i[7:6] == 2'h3 && vbus_i[2:0] == 3'h7);
    endsequence
    sequence bad_byte_s;
        ack_open_s ##0 !(vbus_i[7:6] == 2'h3 && vbus_i[2:0] == 3'h7);
    endsequence

    // request and acknowledge
    irq_invert_a: assert property (!$past(rst_i) |->
        host_irq_o == !$past(periph_irq_n_i)) else $error("request not inverted");
    no_ack_direct_a: assert property (!mode_vectored_i |-> host_int_ack_n_o)
        else $error("ack in direct mode");
    ack_width_a: assert property ($fell(host_int_ack_n_o) |=>
        !host_int_ack_n_o ##1 host_int_ack_n_o) else $error("ack width");
    ack_cause_a: assert property ($fell(host_int_ack_n_o) |->
        mode_vectored_i && $past(insn_done_i)) else $error("ack without cause");
    // vector buffer gating
    buf_gate_a: assert property (vbus_oe_o |-> !host_int_ack_n_o &&
        !$past(periph_irq_n_i) && vbus_o == VEC_OPCODE) else $error("buffer gate");
    buf_idle_a: assert property (host_int_ack_n_o |-> !vbus_oe_o)
        else $error("buffer outside ack");
    // restart and direct targets
    vec_load_a: assert property (good_byte_s |=> pc_load_o &&
        pc_target_o == {10'h000, $past(vbus_i[5:3]), 3'h0}) else $error("restart load");
    vec_err_a: assert property (bad_byte_s |=> vec_err_o && !pc_load_o)
        else $error("bad byte loaded");
    direct_load_a: assert property (pc_load_o && !mode_vectored_i |->
        (pc_target_o == civ_pkg::DIRECT_VEC_ZERO || pc_target_o == civ_pkg::DIRECT_VEC_ONE)
        && $past(!ext_irq_zero_n_i || !ext_irq_one_n_i)) else $error("direct target");
    enable_rise_a: assert property ($rose(host_irq_enabled_o) |->
        $past(ei_i) && !$past(di_i)) else $error("enable without ei");
    // external memory cycle
    mem_addr_a: assert property (ale_o |-> p0_oe_o &&
        p0_o == $past(mem_addr_i[7:0]) && p2_o == $past(mem_addr_i[15:8]))
        else $error("address phase");
    mem_cycle_a: assert property (ale_o |=> !ale_o [*2] ##1 mem_done_o)
        else $error("data phase length");
endmodule

bind civ_host civ_host_monitor #(.VEC_OPCODE(VEC_OPCODE)) u_mon (.*);

// ===== verif/civ_periph_model.sv
// peripheral request source and byte memory on the low port
`timescale 1ns/100ps
module civ_periph_model (
    input  wire logic       clk_i,   // clock
    input  wire logic       rst_i,   // reset
    input  wire logic       set_i,   // cause appears
    input  wire logic       clr_i,   // causes cleared
    input  wire logic       ale_i,   // latch strobe
    input  wire logic       p0_oe_i, // host drives port
    input  wire logic [7:0] p0_i,    // resolved port
    output logic            irq_n_o, // request, low active
    output logic      [7:0] drv_o,   // read byte
    output logic            drv_oe_o // memory drives port
);
    logic       cause_ff;
    logic [7:0] addr_ff;
    logic [1:0] phase_ff;
    logic [7:0] mem [0:255];
    // cause holds request low until cleared
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cause_ff <= 1'b0;
        end else if (set_i) begin
            cause_ff <= 1'b1;
        end
    end
    assign irq_n_o = !cause_ff;
    // low address latched on the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= 2'h0;
        end else if (ale_i) begin
            addr_ff  <= p0_i;
            phase_ff <= 2'h2;
        end else if (phase_ff != 2'h0) begin
            phase_ff <= phase_ff - 2'h1;
            if (phase_ff == 2'h1 && p0_oe_i) begin
                mem[addr_ff] <= p0_i;
            end
        end
    end
    // memory drives only in a read data phase
    assign drv_oe_o = (phase_ff != 2'h0) && !p0_oe_i;
    assign drv_o    = mem[addr_ff];
endmodule

// ===== verif/civ_host_tb.sv
// self-checking bench for the host interrupt controller
`timescale 1ns/100ps
module civ_host_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        mode_v, ei, di, insn, zero_n, one_n, mreq, mwe, set, clr, seen;
    logic [15:0] maddr;
    logic [7:0]  mwd, p0_last, vb_last, vb2_last;
    logic        host_irq, irq_en, ack_n, vbus_oe, pc_load, in_svc, vec_err;
    logic        mdone, ale, p0_oe, irq_n, m_oe, vbus_oe_b, err_b;
    logic [15:0] pc_target;
    logic [7:0]  vbus_d, mrdata, p0_d, p2, m_d, vbus_b;
    wire  [7:0]  p0, vb, vb2;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_load = 0;
    int          i, n0;
    logic        err_seen = 1'b0;
    logic [19:0] r;
    // mode, zero_n, one_n, request_n, target
    logic [19:0] rows [4] = '{{4'h3, 16'h0003}, {4'h5, 16'h0013},
                              {4'h1, 16'h0003}, {4'hE, 16'h0038}};

    always #10 clk_i = ~clk_i;
    // undriven buses show the inverse of their last level
    assign p0  = p0_oe ? p0_d : (m_oe ? m_d : ~p0_last);
    assign vb  = vbus_oe ? vbus_d : ~vb_last;
    assign vb2 = vbus_oe_b ? vbus_b : ~vb2_last;
    always @(posedge clk_i) begin
        p0_last  <= p0;
        vb_last  <= vb;
        vb2_last <= vb2;
        if (pc_load === 1'b1) n_load <= n_load + 1;
        if (err_b === 1'b1) err_seen <= 1'b1;
    end

    civ_host #(.VEC_OPCODE(8'hFF)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .mode_vectored_i(mode_v), .ei_i(ei), .di_i(di),
        .insn_done_i(insn), .periph_irq_n_i(irq_n), .ext_irq_zero_n_i(zero_n),
        .ext_irq_one_n_i(one_n), .vbus_i(vb), .mem_req_i(mreq), .mem_we_i(mwe),
        .mem_addr_i(maddr), .mem_wdata_i(mwd), .p0_i(p0), .host_irq_o(host_irq),
        .host_irq_enabled_o(irq_en), .host_int_ack_n_o(ack_n), .vbus_o(vbus_d),
        .vbus_oe_o(vbus_oe), .pc_load_o(pc_load), .pc_target_o(pc_target),
        .in_service_o(in_svc), .vec_err_o(vec_err), .mem_done_o(mdone),
        .mem_rdata_o(mrdata), .ale_o(ale), .p0_o(p0_d), .p0_oe_o(p0_oe), .p2_o(p2));
    // twin wired to a non-restart byte
    civ_host #(.VEC_OPCODE(8'hC6)) dut_bad (
        .clk_i(clk_i), .rst_i(rst_i), .mode_vectored_i(mode_v), .ei_i(ei), .di_i(di),
        .insn_done_i(insn), .periph_irq_n_i(irq_n), .ext_irq_zero_n_i(zero_n),
        .ext_irq_one_n_i(one_n), .vbus_i(vb2), .mem_req_i(mreq), .mem_we_i(mwe),
        .mem_addr_i(maddr), .mem_wdata_i(mwd), .p0_i(p0), .host_irq_o(),
        .host_irq_enabled_o(), .host_int_ack_n_o(), .vbus_o(vbus_b),
        .vbus_oe_o(vbus_oe_b), .pc_load_o(), .pc_target_o(), .in_service_o(),
        .vec_err_o(err_b), .mem_done_o(), .mem_rdata_o(), .ale_o(), .p0_o(),
        .p0_oe_o(), .p2_o());
    civ_periph_model u_periph (.clk_i(clk_i), .rst_i(rst_i), .set_i(set), .clr_i(clr),
        .ale_i(ale), .p0_oe_i(p0_oe), .p0_i(p0), .irq_n_o(irq_n), .drv_o(m_d),
        .drv_oe_o(m_oe));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // bounded wait for pc load, noting acknowledge
    task automatic wait_load(output logic ack_seen);
        int k;
        ack_seen = 1'b0;
        for (k = 0; k < 12 && pc_load !== 1'b1; k++) begin
            if (ack_n === 1'b0) ack_seen = 1'b1;
            tick(1);
        end
        if (pc_load !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
    endtask
    // one memory cycle, both phases
    task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        mreq  = 1'b1;
        mwe   = w;
        maddr = a;
        mwd   = d;
        tick(1);
        mreq = 1'b0;
        chk(ale, 1'b1);
        chk(p0_d, a[7:0]);
        chk(p2, a[15:8]);
        tick(1);
        chk(p0_oe, w);
        for (k = 0; k < 6 && mdone !== 1'b1; k++) tick(1);
        chk(mdone, 1'b1);
    endtask

    initial begin
        {mode_v, ei, di, insn, mreq, mwe, set, clr} = 8'h00;
        {zero_n, one_n} = 2'h3;
        maddr = 16'h0000;
        mwd = 8'h00;
        tick(10);
        rst_i = 1'b0;
        // ordinary interrupts, one row each
        for (i = 0; i < 4; i++) begin
            r = rows[i];
            mode_v = r[19];
            ei = 1'b1;
            tick(1);
            ei = 1'b0;
            zero_n = r[18];
            one_n = r[17];
            set = !r[16];
            tick(1);
            set = 1'b0;
            tick(2);
            chk(host_irq, r[19]);
            insn = 1'b1;
            tick(1);
            insn = 1'b0;
            wait_load(seen);
            chk(pc_target, r[15:0]);
            chk(seen, r[19]);
            chk(irq_en, 1'b0);
            {zero_n, one_n, clr} = 3'h7;
            tick(1);
            clr = 1'b0;
            tick(3);
            chk(in_svc, 1'b0);
        end
        chk(err_seen, 1'b1);
        // mid-run reset
        ei = 1'b1;
        tick(1);
        ei = 1'b0;
        rst_i = 1'b1;
        tick(2);
        chk({irq_en, ack_n, vbus_oe, p0_oe}, 4'h4);
        chk(pc_target, 16'h0000);
        rst_i = 1'b0;
        // disabled request ignored
        n0 = n_load;
        mode_v = 1'b0;
        zero_n = 1'b0;
        tick(2);
        insn = 1'b1;
        tick(1);
        insn = 1'b0;
        tick(4);
        chk(16'(n_load - n0), 16'h0000);
        zero_n = 1'b1;
        // disable beats enable
        {ei, di} = 2'h3;
        tick(1);
        {ei, di} = 2'h0;
        chk(irq_en, 1'b0);
        ei = 1'b1;
        tick(1);
        ei = 1'b0;
        chk(irq_en, 1'b1);
        // back-to-back memory cycles
        mem(1'b1, 16'h1234, 8'h5A);
        mem(1'b0, 16'hAB34, 8'h00);
        chk(mrdata, 8'h5A);
        mem(1'b1, 16'hFFFF, 8'hC3);
        mem(1'b0, 16'h00FF, 8'h00);
        chk(mrdata, 8'hC3);
        end_of_test();
    end
endmodule
